// ===== shared/dles_pkg.sv
package dles_pkg;
   // register offsets on the processor port
   localparam logic [8:0] EVENT_STATUS_ADDR = 9'h00a;
   localparam logic [8:0] EVENT_ENABLE_ADDR = 9'h012;
   // value of both registers after reset
   localparam logic [7:0] EVENT_RESET_VAL = 8'h00;
   // bit positions in the status register
   localparam int BIT_RX_CODEWORD = 7;
   localparam int BIT_RX_FULL = 6;
   localparam int BIT_RX_NEAR_FULL = 5;
   localparam int BIT_RX_MESSAGE = 4;
   localparam int BIT_TX_UNDERRUN = 3;
   localparam int BIT_TX_OVERFLOW = 2;
   localparam int BIT_TX_NEAR_EMPTY = 1;
   localparam int BIT_TX_MSG_DONE = 0;
   localparam int EVENT_COUNT = 8;
endpackage

// ===== logic/dles_edge_latch.sv
// one sticky event bit: rising edge sets, read clears, set wins
module dles_edge_latch (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_source,
   input wire logic i_clear,
   output logic o_flag
);
   logic src_q;  // source one cycle ago
   logic src_d;
   logic flag_q; // sticky flag
   logic flag_d;

   // next values: edge sets, clear only when no new edge
   always_comb begin
      src_d = i_source;
      if (i_source && !src_q) begin
         flag_d = 1'b1; // a level held high sets only once
      end else if (i_clear) begin
         flag_d = 1'b0; // read clears
      end else begin
         flag_d = flag_q; // hold until read
      end
   end

   // register stage
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         src_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         src_q <= src_d;
         flag_q <= flag_d;
      end
   end

   assign o_flag = flag_q;

   a_edge_sets_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (i_source && !src_q) |=> flag_q)
      else $error("rising source did not set flag");
   a_level_no_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (!flag_q && !(i_source && !src_q)) |=> !flag_q)
      else $error("flag set without rising edge");
   a_hold_until_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (flag_q && !i_clear) |=> flag_q)
      else $error("flag dropped without read");
endmodule

// ===== logic/dles_event_status.sv
// Contract
// - bits set on source rising edge only
// - bits held until read; read clears all, but a new edge in the read cycle wins
// - interrupt only for enabled latched events
// - bit 7 on codeword received
// - bit 6 on receive overrun, hdlc modes
// - bit 6 at fill limit, unformatted modes
// - bit 5 at receive near-full threshold
// - bit 3 on underrun without end marker
// - underrun also forces an abort sequence
// - bit 1 when below near-empty threshold
module dles_event_status (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // processor port, one-cycle strobes
   input wire logic [8:0] i_addr,
   input wire logic i_rd_stb,
   input wire logic i_wr_stb,
   input wire logic [7:0] i_wr_data,
   output logic [7:0] o_rd_data,
   // mode of the data-link receiver
   input wire logic i_six_bit_unformatted_mode,
   input wire logic i_eight_bit_unformatted_mode,
   // event sources from the data-link logic, same clock
   input wire logic i_rx_codeword_valid,
   input wire logic i_rx_overrun,
   input wire logic i_rx_fill_limit_reached,
   input wire logic i_rx_near_full,
   input wire logic i_rx_message_stored,
   input wire logic i_tx_fifo_empty_no_eom,
   input wire logic i_tx_overflow,
   input wire logic i_tx_below_near_empty,
   input wire logic i_tx_closing_flag,
   // outputs
   output logic o_tx_abort_req,
   output logic o_irq
);
   // companion enable register, written by the processor
   logic [7:0] enable_q; // datalink2_event_enable
   logic [7:0] enable_d;
   // read data is registered so the port sees a clean byte
   logic [7:0] rd_data_q; // read data register
   logic [7:0] rd_data_d;
   logic abort_q; // abort request level
   logic abort_d;
   // source history mirrors the latches, so checks agree at reset
   logic [7:0] sources_q; // sources one cycle ago
   logic [7:0] sources_d;
   logic [7:0] new_edges; // sources that rose this cycle
   logic [7:0] sources; // per-bit event source
   logic [7:0] flags; // latched event bits
   // decoded processor accesses
   logic status_rd; // read of the status register
   logic enable_rd; // read of the enable register
   logic enable_wr; // write of the enable register
   logic unmapped_rd; // read of any other address
   logic unformatted; // either unformatted packing mode

   // address decode used by read and write paths
   function automatic logic hit(input logic [8:0] a, input logic [8:0] target);
      hit = (a == target);
   endfunction

   // strobe qualifiers; a write to status matches nothing and is dropped
   assign status_rd = i_rd_stb && hit(i_addr, dles_pkg::EVENT_STATUS_ADDR);
   assign enable_rd = i_rd_stb && hit(i_addr, dles_pkg::EVENT_ENABLE_ADDR);
   assign enable_wr = i_wr_stb && hit(i_addr, dles_pkg::EVENT_ENABLE_ADDR);
   assign unmapped_rd = i_rd_stb && !status_rd && !enable_rd;
   assign unformatted = i_six_bit_unformatted_mode || i_eight_bit_unformatted_mode;
   // an edge as each latch sees it; history is zero after reset
   assign new_edges = sources & ~sources_q;

   // map sources onto status bit positions
   always_comb begin
      sources = 8'h00;
      sources[dles_pkg::BIT_RX_CODEWORD] = i_rx_codeword_valid;
      // bit 6 meaning depends on packing mode
      sources[dles_pkg::BIT_RX_FULL] = unformatted ? i_rx_fill_limit_reached
                                                   : i_rx_overrun;
      sources[dles_pkg::BIT_RX_NEAR_FULL] = i_rx_near_full;
      sources[dles_pkg::BIT_RX_MESSAGE] = i_rx_message_stored;
      sources[dles_pkg::BIT_TX_UNDERRUN] = i_tx_fifo_empty_no_eom;
      // overflow meaning is only partly known; latched like the rest
      sources[dles_pkg::BIT_TX_OVERFLOW] = i_tx_overflow;
      sources[dles_pkg::BIT_TX_NEAR_EMPTY] = i_tx_below_near_empty;
      sources[dles_pkg::BIT_TX_MSG_DONE] = i_tx_closing_flag;
   end

   // one sticky latch per bit
   for (genvar g = 0; g < dles_pkg::EVENT_COUNT; g++) begin : g_latch
      dles_edge_latch u_latch (
         .i_core_clk(i_core_clk),
         .i_rst_n(i_rst_n),
         .i_source(sources[g]),
         .i_clear(status_rd),
         .o_flag(flags[g])
      );
   end

   // register next values: enable write, read data, abort, history
   always_comb begin
      enable_d = enable_q;
      if (enable_wr) begin
         enable_d = i_wr_data; // whole byte, no reserved bits
      end
      rd_data_d = rd_data_q; // holds until the next read
      if (i_rd_stb) begin
         // pre-read value is returned; unmapped reads give zero
         if (status_rd) begin
            rd_data_d = flags;
         end else if (enable_rd) begin
            rd_data_d = enable_q;
         end else begin
            rd_data_d = 8'h00;
         end
      end
      // abort follows the underrun condition itself, not the sticky bit,
      // so clearing status never cuts an abort short
      abort_d = i_tx_fifo_empty_no_eom;
      sources_d = sources;
   end

   // register stage
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         enable_q <= dles_pkg::EVENT_RESET_VAL;
         rd_data_q <= dles_pkg::EVENT_RESET_VAL;
         abort_q <= 1'b0;
         sources_q <= dles_pkg::EVENT_RESET_VAL; // same as the latches' history
      end else begin
         enable_q <= enable_d;
         rd_data_q <= rd_data_d;
         abort_q <= abort_d;
         sources_q <= sources_d;
      end
   end

   assign o_rd_data = rd_data_q;
   assign o_tx_abort_req = abort_q;
   assign o_irq = |(flags & enable_q);

   // interrupt may only rise through a new enabled edge or an enable write
   a_irq_needs_enable: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (!o_irq && !enable_wr && !(|(new_edges & enable_q))) |=> !o_irq)
      else $error("interrupt without enabled flag");
   a_irq_on_enabled: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (|(new_edges & enable_q) && !enable_wr) |=> o_irq)
      else $error("enabled event raised no interrupt");
   a_irq_drops_on_read: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (status_rd && !(|new_edges)) |=> !o_irq)
      else $error("interrupt survived a status read");
   // read port: status returns then clears, enable reads back, others give zero
   a_read_clears_all: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (status_rd && !(|new_edges)) |=> flags == 8'h00)
      else $error("status read did not clear");
   a_read_gives_flags: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      status_rd |=> o_rd_data == $past(flags))
      else $error("status read returned wrong byte");
   a_enable_readback: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      enable_rd |=> o_rd_data == $past(enable_q))
      else $error("enable read returned wrong byte");
   a_unmapped_zero: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      unmapped_rd |=> o_rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_rd_data_holds: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !i_rd_stb |=> $stable(o_rd_data))
      else $error("read data changed without a read");
   a_enable_write: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      enable_wr |=> enable_q == $past(i_wr_data))
      else $error("enable write did not land");
   // receive side: each source sets its bit one cycle after it rises; overrun and fill limit set bit 6 only in their own modes
   a_codeword_sets: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(i_rx_codeword_valid) |=> flags[7])
      else $error("codeword bit not set");
   a_overrun_hdlc: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (!unformatted && $rose(i_rx_overrun) && $stable(unformatted)) |=> flags[6])
      else $error("overrun bit not set");
   a_fill_unformatted: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (unformatted && $rose(i_rx_fill_limit_reached) && $stable(unformatted))
      |=> flags[6])
      else $error("fill limit bit not set");
   a_near_full_sets: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(i_rx_near_full) |=> flags[5])
      else $error("near full bit not set");
   a_message_sets: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(i_rx_message_stored) |=> flags[4])
      else $error("message bit not set");
   // transmit side: underrun also drives the abort request while it lasts
   a_underrun_abort: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(i_tx_fifo_empty_no_eom) |=> (flags[3] && o_tx_abort_req))
      else $error("underrun bit or abort missing");
   a_abort_follows: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_tx_abort_req |-> $past(i_tx_fifo_empty_no_eom))
      else $error("abort without underrun");
   a_abort_drops: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !i_tx_fifo_empty_no_eom |=> !o_tx_abort_req)
      else $error("abort outlived the underrun");
   a_near_empty_sets: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(i_tx_below_near_empty) |=> flags[1])
      else $error("near empty bit not set");
   a_msg_done_sets: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(i_tx_closing_flag) |=> flags[0])
      else $error("message done bit not set");
   // overflow has no documented meaning beyond a rising source
   a_overflow_sets: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(i_tx_overflow) |=> flags[dles_pkg::BIT_TX_OVERFLOW])
      else $error("overflow bit not set");
endmodule

// ===== testbench/dles_host_model.sv
// processor side of the register port
module dles_host_model (
   input wire logic i_clk,
   output logic [8:0] o_addr,
   output logic o_rd_stb,
   output logic o_wr_stb,
   output logic [7:0] o_wr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // bus idle at time zero
   initial begin
      o_addr = 9'h000;
      o_rd_stb = 1'b0;
      o_wr_stb = 1'b0;
      o_wr_data = 8'h00;
   end
   // one-cycle strobe; released address and data are inverted and strobes drop low, so stale values never look valid
   task automatic access(input logic [8:0] a, input logic w, input logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd_stb <= !w;
      o_wr_stb <= w;
      o_wr_data <= d;
      @(posedge i_clk);
      o_addr <= ~a;
      o_rd_stb <= 1'b0;
      o_wr_stb <= 1'b0;
      o_wr_data <= ~d;
   endtask
endmodule

// ===== testbench/dles_event_status_tb.sv
module dles_event_status_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [8:0] src = 9'h000; // codeword, overrun, fill, then bits 5..0
   logic [1:0] mode = 2'b00; // six-bit, eight-bit
   logic [8:0] addr;
   logic rd, wr, abort, irq, rd_d = 1'b0;
   logic [7:0] wd, rdata, en = 8'h00, mf = 8'h00;
   logic [7:0] exp_q[$]; // expected read data, oldest first
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;
   always #25 clk = ~clk;
   dles_host_model u_dles_host_model (.i_clk(clk), .o_addr(addr), .o_rd_stb(rd),
      .o_wr_stb(wr), .o_wr_data(wd));
   dles_event_status u_dles_event_status (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
      .i_rd_stb(rd), .i_wr_stb(wr), .i_wr_data(wd), .o_rd_data(rdata),
      .i_six_bit_unformatted_mode(mode[0]), .i_eight_bit_unformatted_mode(mode[1]),
      .i_rx_codeword_valid(src[0]), .i_rx_overrun(src[1]), .i_rx_fill_limit_reached(src[2]),
      .i_rx_near_full(src[3]), .i_rx_message_stored(src[4]), .i_tx_fifo_empty_no_eom(src[5]),
      .i_tx_overflow(src[6]), .i_tx_below_near_empty(src[7]), .i_tx_closing_flag(src[8]),
      .o_tx_abort_req(abort), .o_irq(irq));
   // sources mapped to status bits; bit 6 meaning follows the mode
   function automatic logic [7:0] ev(input logic [8:0] s);
      return {s[0], (|mode) ? s[2] : s[1], s[3], s[4], s[5], s[6], s[7], s[8]};
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // new source levels, then let flags settle; only rising edges add to the note
   task automatic drive(input logic [8:0] s);
      mf = mf | (ev(s) & ~ev(src));
      @(posedge clk);
      src <= s;
      repeat (2) @(posedge clk);
      check({7'h00, irq}, {7'h00, |(mf & en)});
      check({7'h00, abort}, {7'h00, s[5]});
   endtask
   task automatic rd_reg(input logic [8:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      u_dles_host_model.access(a, 1'b0, 8'h00);
   endtask
   task automatic wr_en(input logic [7:0] v);
      u_dles_host_model.access(dles_pkg::EVENT_ENABLE_ADDR, 1'b1, v);
      en = v;
   endtask
   // read data lands one cycle after the strobe edge
   always @(posedge clk) begin
      if (rd_d) check(rdata, exp_q.pop_front());
      rd_d <= rd;
      cyc++;
      if (cyc > 6000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(32'he5870f88));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      wr_en(8'hff);
      // writes to status must not set anything
      u_dles_host_model.access(dles_pkg::EVENT_STATUS_ADDR, 1'b1, 8'hff);
      rd_reg(9'h0ff, 8'h00);
      rd_reg(dles_pkg::EVENT_STATUS_ADDR, 8'h00);
      // each source alone in each mode; second read shows steady high adds nothing
      for (int m = 0; m < 3; m++) begin
         @(posedge clk);
         mode <= m[1:0];
         for (int i = 0; i < 9; i++) begin
            drive(9'h001 << i);
            rd_reg(dles_pkg::EVENT_STATUS_ADDR, mf);
            mf = 8'h00;
            rd_reg(dles_pkg::EVENT_STATUS_ADDR, 8'h00);
            drive(9'h000);
         end
      end
      wr_en(8'($urandom));
      rd_reg(dles_pkg::EVENT_ENABLE_ADDR, en);
      repeat (40) begin
         drive(9'($urandom));
         if ($urandom % 3 == 0) begin
            rd_reg(dles_pkg::EVENT_STATUS_ADDR, mf);
            mf = 8'h00;
         end
      end
      drive(9'h000);
      rd_reg(dles_pkg::EVENT_STATUS_ADDR, mf);
      repeat (3) @(posedge clk);
      give_verdict();
   end
endmodule
